/* File: design/wsr_pkg.sv */
// wsr_pkg: constants, states and bus carriers for the watchdog / stop recovery block
// assumes a single 250 MHz clock that also stands for the crystal clock
package wsr_pkg;

	// register byte offsets
	localparam logic [7:0]  WSR_OFS_CTRL      = 8'h00;
	localparam logic [7:0]  WSR_OFS_PORTCFG   = 8'h04;
	localparam logic [7:0]  WSR_OFS_FLAGS     = 8'h08;
	localparam logic [7:0]  WSR_OFS_STATUS    = 8'h0C;
	localparam logic [7:0]  WSR_OFS_CMD       = 8'h10;

	// field positions
	localparam int          WSR_CTRL_SEL_LO   = 4;
	localparam int          WSR_CTRL_SEL_HI   = 6;
	localparam int          WSR_CTRL_DIS_BIT  = 0;
	localparam int          WSR_PCFG_DIR_BIT  = 0;
	localparam int          WSR_PCFG_SPF_BIT  = 1;
	localparam int          WSR_FLAG_SMR_BIT  = 0;
	localparam int          WSR_FLAG_WDT_BIT  = 1;
	localparam int          WSR_CMD_RST_BIT   = 0;
	localparam int          WSR_CMD_STOP_BIT  = 1;
	localparam int          WSR_STAT_ST_LO    = 16;

	// reset values
	localparam logic [2:0]  WSR_SEL_RST       = 3'h0;
	localparam logic [1:0]  WSR_PCFG_RST      = 2'h0;
	localparam logic [15:0] WSR_VECTOR        = 16'h0020;
	localparam logic [12:0] WSR_RELOAD_LOW    = 13'h1FFF;

	// timing
	localparam int          WSR_WDT_DIV       = 64;
	localparam int          WSR_POR_CYCLES    = 64;
	localparam int          WSR_FETCH_CYCLES  = 10;
	localparam int          WSR_CLK_PS        = 4000;
	localparam int          WSR_REC_MIN_PS    = 100000;
	localparam int          WSR_REC_CYCLES    = (WSR_REC_MIN_PS + WSR_CLK_PS - 1) / WSR_CLK_PS;

	typedef enum logic [1:0] {
		WSR_ST_DELAY = 2'b00,
		WSR_ST_FETCH = 2'b01,
		WSR_ST_RUN   = 2'b11,
		WSR_ST_STOP  = 2'b10
	} wsr_state_e;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} wsr_ahb_in_s;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} wsr_ahb_out_s;

endpackage

/* File: design/wsr_top.sv */
// wsr_top: watchdog, stop mode entry and stop recovery with an ahb-lite register slave
// assumes clk_sys stays alive in stop; the gated clocks are reported by the enable outputs
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - watchdog is a 16-bit retriggerable one-shot that resets on terminal count
// - watchdog counter steps once every 64 crystal clock cycles
// - timeout in run loads pc with 0020H and sets watchdog flag
// - after reset watchdog runs with minimum timeout unless first write changes it
// - restart reloads counter from select bits 6..4 of timer control high
// - watchdog disable only possible right after reset; stop mode halts it
// - timeout in same cycle as restart wins; restart ignored
// - system reset clears both watchdog and stop recovery flags
// - timeout sets watchdog flag; stop instruction sets stop recovery flag
// - reading flags leaves them; only software write or reset clears
// - stop instruction alone enters stop mode, no preceding nop
// - stop mode switches off oscillator and system clock
// - stop left only by reset or recovery; restart at 0020H, flag set
// - low recovery pin wakes only if input with special function before stop
// - after pin wake-up execution starts at 20h once power-on delay elapsed
// - pin wake-up keeps control registers instead of reset defaults
// - power-on delay counts 64 internal clock cycles before release
// - fetch starts 10 crystal cycles after power-on delay
// - wake-up or timeout leaves control registers and ports unchanged
module wsr_top #(
	parameter int REC_CYCLES = wsr_pkg::WSR_REC_CYCLES
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire wsr_pkg::wsr_ahb_in_s  ahb_in,
	output wsr_pkg::wsr_ahb_out_s      ahb_out,
	input  wire logic                  instr_restart,
	input  wire logic                  instr_stop,
	input  wire logic                  recovery_input_pin,
	output logic                       osc_enable,
	output logic                       sys_clk_enable,
	output logic                       fetch_enable,
	output logic                       pc_load,
	output logic [15:0]                pc_vector,
	output logic                       wdt_reset
);
	import wsr_pkg::*;

	wsr_state_e  state_r;
	logic [2:0]  sel_r;
	logic        wdt_dis_r;
	logic        dis_window_r;
	logic [1:0]  pcfg_r;
	logic        flag_wdt_r;
	logic        flag_smr_r;
	logic [15:0] wdt_cnt_r;
	logic [5:0]  div_r;
	logic [6:0]  dly_r;
	logic        armed_r;
	logic [1:0]  pin_sync_r;
	logic [15:0] low_cnt_r;
	logic        pc_load_r;
	logic        wdt_reset_r;

	// ahb address phase capture
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic [31:0] rdata_r;
	logic        take;
	logic        bus_wr;
	logic        wr_ctrl;
	logic        wr_pcfg;
	logic        wr_flags;
	logic        wr_cmd;
	logic        restart;
	logic        stop_go;
	logic        tick;
	logic        timeout;
	logic        wake;
	logic [15:0] reload;

	assign take     = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
	assign bus_wr   = wr_pend_r;
	assign wr_ctrl  = bus_wr && (wr_addr_r == WSR_OFS_CTRL);
	assign wr_pcfg  = bus_wr && (wr_addr_r == WSR_OFS_PORTCFG);
	assign wr_flags = bus_wr && (wr_addr_r == WSR_OFS_FLAGS);
	assign wr_cmd   = bus_wr && (wr_addr_r == WSR_OFS_CMD);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= take && ahb_in.hwrite;
			wr_addr_r <= ahb_in.haddr[7:0];
		end
	end

	// read data registered in the address phase so the slave never waits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (take && !ahb_in.hwrite) begin
			case (ahb_in.haddr[7:0])
				WSR_OFS_CTRL:    rdata_r <= {25'h0, sel_r, 3'h0, wdt_dis_r};
				WSR_OFS_PORTCFG: rdata_r <= {30'h0, pcfg_r};
				WSR_OFS_FLAGS:   rdata_r <= {30'h0, flag_wdt_r, flag_smr_r};
				WSR_OFS_STATUS:  rdata_r <= {14'h0, state_r, wdt_cnt_r};
				default:         rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign ahb_out.hreadyout = 1'b1;
	assign ahb_out.hresp     = 1'b0;
	assign ahb_out.hrdata    = rdata_r;

	// control registers reset only by rst, never by wake-up or timeout
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sel_r  <= WSR_SEL_RST;
			pcfg_r <= WSR_PCFG_RST;
		end else begin
			if (wr_ctrl) begin
				sel_r <= ahb_in.hwdata[WSR_CTRL_SEL_HI:WSR_CTRL_SEL_LO];
			end
			if (wr_pcfg) begin
				pcfg_r <= {ahb_in.hwdata[WSR_PCFG_SPF_BIT], ahb_in.hwdata[WSR_PCFG_DIR_BIT]};
			end
		end
	end

	// disable accepted only by the first control write after release, and only if no restart or stop came before it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdt_dis_r    <= 1'b0;
			dis_window_r <= 1'b1;
		end else begin
			if (wr_ctrl && dis_window_r) begin
				wdt_dis_r <= ahb_in.hwdata[WSR_CTRL_DIS_BIT];
			end
			if (wr_ctrl || restart || stop_go) begin
				dis_window_r <= 1'b0;
			end
		end
	end

	// instructions only act in run; a restart or stop seen during the delay is dropped
	assign restart = (state_r == WSR_ST_RUN)
		&& (instr_restart || (wr_cmd && ahb_in.hwdata[WSR_CMD_RST_BIT]));
	assign stop_go = (state_r == WSR_ST_RUN)
		&& (instr_stop || (wr_cmd && ahb_in.hwdata[WSR_CMD_STOP_BIT]));
	assign reload  = {sel_r, WSR_RELOAD_LOW};

	// prescaler: watchdog advances once per 64 crystal cycles
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_r <= 6'h00;
		end else if (state_r == WSR_ST_RUN) begin
			div_r <= div_r + 6'h01;
		end
	end
	assign tick = (state_r == WSR_ST_RUN) && (div_r == 6'(WSR_WDT_DIV - 1));

	assign timeout = tick && !wdt_dis_r && (wdt_cnt_r == 16'h0000);

	// timeout is tested first so a restart in the same cycle cannot mask it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdt_cnt_r <= {WSR_SEL_RST, WSR_RELOAD_LOW};
		end else if (timeout) begin
			wdt_cnt_r <= reload;
		end else if (restart) begin
			wdt_cnt_r <= reload;
		end else if (tick && !wdt_dis_r) begin
			wdt_cnt_r <= wdt_cnt_r - 16'h0001;
		end
	end

	// flags: hardware set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_wdt_r <= 1'b0;
			flag_smr_r <= 1'b0;
		end else begin
			if (timeout) begin
				flag_wdt_r <= 1'b1;
			end else if (wr_flags && ahb_in.hwdata[WSR_FLAG_WDT_BIT]) begin
				flag_wdt_r <= 1'b0;
			end
			if (stop_go) begin
				flag_smr_r <= 1'b1;
			end else if (wr_flags && ahb_in.hwdata[WSR_FLAG_SMR_BIT]) begin
				flag_smr_r <= 1'b0;
			end
		end
	end

	// recovery pin: two-stage synchroniser then a low-width filter
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_sync_r <= 2'b11;
		end else begin
			pin_sync_r <= {pin_sync_r[0], recovery_input_pin};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			low_cnt_r <= 16'h0000;
		end else if (state_r != WSR_ST_STOP || pin_sync_r[1]) begin
			low_cnt_r <= 16'h0000;
		end else if (low_cnt_r != 16'(REC_CYCLES)) begin
			low_cnt_r <= low_cnt_r + 16'h0001;
		end
	end

	// pin config is frozen at stop entry, later writes cannot arm it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed_r <= 1'b0;
		end else if (stop_go) begin
			armed_r <= !pcfg_r[0] && pcfg_r[1];
		end
	end

	assign wake = (state_r == WSR_ST_STOP) && armed_r
		&& (low_cnt_r == 16'(REC_CYCLES));

	// sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= WSR_ST_DELAY;
			dly_r   <= 7'h00;
		end else begin
			case (state_r)
				WSR_ST_DELAY: begin
					if (dly_r == 7'(WSR_POR_CYCLES - 1)) begin
						state_r <= WSR_ST_FETCH;
						dly_r   <= 7'h00;
					end else begin
						dly_r <= dly_r + 7'h01;
					end
				end
				WSR_ST_FETCH: begin
					if (dly_r == 7'(WSR_FETCH_CYCLES - 1)) begin
						state_r <= WSR_ST_RUN;
						dly_r   <= 7'h00;
					end else begin
						dly_r <= dly_r + 7'h01;
					end
				end
				WSR_ST_RUN: begin
					if (stop_go && !timeout) begin
						state_r <= WSR_ST_STOP;
					end
				end
				WSR_ST_STOP: begin
					if (wake) begin
						state_r <= WSR_ST_DELAY;
					end
				end
				default: begin
					state_r <= WSR_ST_DELAY;
				end
			endcase
		end
	end

	// pc load at fetch release and on timeout, both to the restart vector
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc_load_r   <= 1'b0;
			wdt_reset_r <= 1'b0;
		end else begin
			pc_load_r   <= timeout
				|| (state_r == WSR_ST_FETCH && dly_r == 7'(WSR_FETCH_CYCLES - 1));
			wdt_reset_r <= timeout;
		end
	end

	assign pc_load        = pc_load_r;
	assign pc_vector      = WSR_VECTOR;
	assign wdt_reset      = wdt_reset_r;
	assign osc_enable     = (state_r != WSR_ST_STOP);
	assign sys_clk_enable = (state_r != WSR_ST_STOP);
	assign fetch_enable   = (state_r == WSR_ST_RUN);

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_timeout_flag: assert property (timeout |=> flag_wdt_r && wdt_reset && pc_load)
		else $error("timeout did not set flag and load pc");
	chk_restart_loses: assert property (timeout && restart |=> wdt_reset && flag_wdt_r
		&& wdt_cnt_r == $past(reload))
		else $error("timeout and restart collision mishandled");
	chk_restart_load: assert property (restart && !timeout |=> wdt_cnt_r == $past(reload))
		else $error("restart did not reload counter");
	chk_step_rate: assert property (!tick && !restart && !timeout |=> $stable(wdt_cnt_r))
		else $error("counter moved without prescaler tick");
	chk_count_down: assert property (tick && !wdt_dis_r && !restart && wdt_cnt_r != 16'h0000
		|=> wdt_cnt_r == $past(wdt_cnt_r) - 16'h0001)
		else $error("counter did not decrement");
	chk_stop_hold: assert property (state_r == WSR_ST_STOP
		|-> (!timeout && !osc_enable && !sys_clk_enable) ##1 $stable(wdt_cnt_r))
		else $error("watchdog active or clock on in stop");
	chk_stop_entry: assert property (stop_go && !timeout |=> state_r == WSR_ST_STOP && flag_smr_r)
		else $error("stop instruction did not enter stop");
	chk_flag_read: assert property (!timeout && !wr_flags |=> $stable(flag_wdt_r))
		else $error("watchdog flag changed without cause");
	chk_wake_arm: assert property (state_r == WSR_ST_STOP && !armed_r |=> state_r == WSR_ST_STOP)
		else $error("woke without armed recovery pin");
	chk_por_delay: assert property ($rose(state_r == WSR_ST_DELAY)
		|-> (state_r == WSR_ST_DELAY) [*8] ##0 !fetch_enable)
		else $error("power-on delay cut short");
	chk_keep_cfg: assert property (wake |=> $stable(sel_r) && $stable(pcfg_r))
		else $error("wake-up changed control registers");

	// the disable bit is a one-time choice; later control writes must leave it
	chk_dis_window: assert property (wr_ctrl && !dis_window_r |=> $stable(wdt_dis_r))
		else $error("watchdog disable changed after window closed");
	chk_reset_flags: assert property (disable iff (1'b0)
		rst |=> !flag_wdt_r && !flag_smr_r)
		else $error("reset did not clear source flags");
	chk_smr_flag: assert property (!stop_go && !wr_flags |=> $stable(flag_smr_r))
		else $error("stop flag changed without cause");
	chk_delay_len: assert property (state_r == WSR_ST_DELAY
		&& dly_r != 7'(WSR_POR_CYCLES - 1) |=> state_r == WSR_ST_DELAY)
		else $error("power-on delay left early");
	chk_fetch_len: assert property (state_r == WSR_ST_FETCH
		&& dly_r != 7'(WSR_FETCH_CYCLES - 1) |=> state_r == WSR_ST_FETCH)
		else $error("fetch wait left early");
	chk_fetch_go: assert property (state_r == WSR_ST_FETCH
		&& dly_r == 7'(WSR_FETCH_CYCLES - 1) |=> pc_load && fetch_enable)
		else $error("fetch release did not load the vector");
	// arming is decided once, at stop entry
	chk_arm_frozen: assert property (state_r == WSR_ST_STOP |=> $stable(armed_r))
		else $error("recovery arming changed during stop");
	chk_short_low: assert property (state_r == WSR_ST_STOP && pin_sync_r[1] |=> !wake)
		else $error("recovery taken without a held low level");

	cov_timeout: cover property (timeout);
	cov_restart: cover property (restart);
	cov_stop: cover property (stop_go ##1 state_r == WSR_ST_STOP);
	cov_wake: cover property (wake ##1 state_r == WSR_ST_DELAY);
	cov_collide: cover property (timeout && restart);

endmodule

/* File: dv/wsr_rec_src.sv */
// wsr_rec_src: external source that pulls the recovery pin low on request
// assumes a pull-up on the pin, so the released level is high
`timescale 1ns/1ps
module wsr_rec_src (
	input  wire logic       clk_sys,
	input  wire logic       go,
	input  wire logic [7:0] width,
	output logic            pin
);
	logic [7:0] left_r = 8'h00;
	// low for exactly width cycles, then released to the pull-up level
	always @(posedge clk_sys) begin
		if (go)
			left_r <= width;
		else if (left_r != 8'h00)
			left_r <= left_r - 8'h01;
	end
	assign pin = (left_r == 8'h00);
endmodule

/* File: dv/tb_watchdog_stop_recovery.sv */
// tb_watchdog_stop_recovery: directed tests of watchdog ticking, restart and stop recovery
// assumes hreadyout feeds hready; timeout itself needs over 500k cycles so is not reached
`timescale 1ns/1ps
module tb_watchdog_stop_recovery;
	import wsr_pkg::*;
	logic         clk_sys, rst, instr_restart, instr_stop, go, pin;
	logic         osc_enable, sys_clk_enable, fetch_enable, pc_load, wdt_reset;
	logic [15:0]  pc_vector;
	logic [31:0]  rd, c0;
	int           err_count, check_count, n;
	wsr_ahb_in_s  m, bus_in;
	wsr_ahb_out_s bus_out;

	wsr_top #(.REC_CYCLES(3)) wsr_top_i (.clk_sys(clk_sys), .rst(rst), .ahb_in(bus_in),
		.ahb_out(bus_out), .instr_restart(instr_restart), .instr_stop(instr_stop),
		.recovery_input_pin(pin), .osc_enable(osc_enable), .sys_clk_enable(sys_clk_enable),
		.fetch_enable(fetch_enable), .pc_load(pc_load), .pc_vector(pc_vector),
		.wdt_reset(wdt_reset));
	wsr_rec_src wsr_rec_src_i (.clk_sys(clk_sys), .go(go), .width(8'h05), .pin(pin));

	always #2 clk_sys = ~clk_sys;
	always_comb begin
		bus_in = m;
		bus_in.hready = bus_out.hreadyout;
	end

	task chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		m.hsel <= 1'b1;
		m.haddr <= {24'h000000, a};
		m.htrans <= 2'h2;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		do @(posedge clk_sys); while (bus_out.hreadyout !== 1'b1);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= wd;
		do @(posedge clk_sys); while (bus_out.hreadyout !== 1'b1);
		rd = bus_out.hrdata;
	endtask

	task do_reset();
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
	endtask

	task t_boot();
		do_reset();
		repeat (73) @(posedge clk_sys);
		#1 chk(pc_load === 1'b0 && fetch_enable === 1'b0, "early fetch");
		@(posedge clk_sys);
		#1 chk(pc_load === 1'b1 && fetch_enable === 1'b1, "no fetch at 74");
		chk(pc_vector === WSR_VECTOR, "vector");
		@(posedge clk_sys);
		bus(1'b0, WSR_OFS_FLAGS, 32'h0);
		chk(rd[1:0] === 2'h0 && bus_out.hresp === 1'b0, "flags after reset");
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(rd[15:0] === 16'h1FFF || rd[15:0] === 16'h1FFE, "initial count");
		$display("test boot done");
	endtask

	task t_tick();
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		c0 = rd;
		repeat (62) @(posedge clk_sys);
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(c0[15:0] - rd[15:0] === 16'h0001, "one step per 64");
		bus(1'b1, WSR_OFS_CTRL, 32'h30);
		bus(1'b1, WSR_OFS_CMD, 32'h1);
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(rd[15:0] === 16'h7FFF || rd[15:0] === 16'h7FFE, "restart reload");
		bus(1'b1, WSR_OFS_CTRL, 32'h51);
		instr_restart <= 1'b1;
		@(posedge clk_sys);
		instr_restart <= 1'b0;
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(rd[15:0] === 16'hBFFF || rd[15:0] === 16'hBFFE, "instr restart");
		bus(1'b0, WSR_OFS_CTRL, 32'h0);
		chk(rd[0] === 1'b0 && rd[6:4] === 3'h5, "late disable taken");
		$display("test tick done");
	endtask

	task stop_pulse();
		bus(1'b1, WSR_OFS_CMD, 32'h2);
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
	endtask

	// armed pin: wake, registers kept, flag sticky until written
	task t_armed();
		bus(1'b1, WSR_OFS_PORTCFG, 32'h2);
		instr_stop <= 1'b1;
		@(posedge clk_sys);
		instr_stop <= 1'b0;
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		c0 = rd;
		chk(rd[17:16] === WSR_ST_STOP, "not stopped");
		chk(osc_enable === 1'b0 && sys_clk_enable === 1'b0, "clocks on");
		repeat (100) @(posedge clk_sys);
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(rd[15:0] === c0[15:0] && wdt_reset === 1'b0, "count moved");
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		n = 0;
		while (pc_load !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		chk(pc_load === 1'b1 && n > 74, "no wake");
		bus(1'b0, WSR_OFS_CTRL, 32'h0);
		chk(rd[6:4] === 3'h5, "ctrl lost");
		bus(1'b0, WSR_OFS_PORTCFG, 32'h0);
		chk(rd[1:0] === 2'h2, "portcfg lost");
		bus(1'b0, WSR_OFS_FLAGS, 32'h0);
		chk(rd[0] === 1'b1, "stop flag");
		bus(1'b0, WSR_OFS_FLAGS, 32'h0);
		chk(rd[0] === 1'b1, "read cleared");
		bus(1'b1, WSR_OFS_FLAGS, 32'h1);
		bus(1'b0, WSR_OFS_FLAGS, 32'h0);
		chk(rd[0] === 1'b0, "write clear");
		$display("test armed done");
	endtask

	// pin set as output: pulse ignored, only reset leaves stop
	task t_unarmed();
		bus(1'b1, WSR_OFS_PORTCFG, 32'h3);
		stop_pulse();
		repeat (150) @(posedge clk_sys);
		bus(1'b0, WSR_OFS_STATUS, 32'h0);
		chk(rd[17:16] === WSR_ST_STOP, "woke unarmed");
		do_reset();
		bus(1'b0, WSR_OFS_FLAGS, 32'h0);
		chk(rd[1:0] === 2'h0, "flags kept");
		$display("test unarmed done");
	endtask

	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		m = '0;
		instr_restart = 1'b0;
		instr_stop = 1'b0;
		go = 1'b0;
		err_count = 0;
		check_count = 0;
		t_boot();
		t_tick();
		t_armed();
		t_unarmed();
		wrap_up();
	end

	// whole run is about 520 cycles
	initial begin
		#80000;
		err_count++;
		wrap_up();
	end
endmodule
